// ---- common/fdlp_regs.vh ----
// register map, field positions and reset values of the link byte port
`ifndef FDLP_REGS_VH
`define FDLP_REGS_VH
// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define FDLP_IDX_RX_BYTE   8'h28
`define FDLP_IDX_MATCH_A   8'h29
`define FDLP_IDX_MATCH_B   8'h2a
`define FDLP_IDX_TX_BYTE   8'h7e
`define FDLP_IDX_CTRL      8'h80
`define FDLP_IDX_STATUS    8'h81
`define FDLP_IDX_MASK      8'h82
// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define FDLP_CTRL_DESTUFF  0
`define FDLP_CTRL_STUFF    1
`define FDLP_CTRL_MFLOAD   2
`define FDLP_CTRL_FSSRC    3
`define FDLP_CTRL_ESF      4
// ----------------------------------------------------------------------
// status and mask fields
// ----------------------------------------------------------------------
`define FDLP_ST_MATCH      0
`define FDLP_ST_TXEMPTY    1
`define FDLP_ST_RXFULL     2
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FDLP_RST_BYTE      8'h00
`define FDLP_RST_CTRL      5'h00
`define FDLP_RST_FLAGS     3'h0
// ----------------------------------------------------------------------
// bit stuffing run length
// ----------------------------------------------------------------------
`define FDLP_RUN_ONES      3'h5
`endif

// ---- rtl/fdlp_sync.v ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module fdlp_sync #(
	parameter WIDTH = 1
) (
	input  wire             i_clk,
	input  wire             i_rst_n,
	input  wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_sync
);
	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;

	// first stage is read only by the second
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
		end else begin
			stage1_reg <= i_async;
			stage2_reg <= stage1_reg;
		end
	end

	assign o_sync = stage2_reg;
endmodule

// ---- rtl/fdlp_top.v ----
// facility data link byte port: apb registers, rx assembly, tx serialiser
`timescale 1ns/100ps
`include "fdlp_regs.vh"
module fdlp_top (
	input  wire        I_CLK_SYS,
	input  wire        I_RST_N,
	input  wire        I_PSEL,
	input  wire        I_PENABLE,
	input  wire        I_PWRITE,
	input  wire [11:0] I_PADDR,
	input  wire [31:0] I_PWDATA,
	output wire [31:0] O_PRDATA,
	output wire        O_PREADY,
	output wire        O_PSLVERR,
	input  wire        I_RX_BIT,
	input  wire        I_RX_STROBE,
	input  wire        I_TX_REQ,
	input  wire        I_TX_MF_START,
	output wire        O_TX_BIT,
	output wire        O_TX_VALID,
	output wire        O_INT_N
);
	// ------------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------------
	wire [3:0] pins_sync;
	wire       rx_bit;
	wire       rx_strobe_lvl;
	wire       tx_req_lvl;
	wire       tx_mf_lvl;
	reg  [2:0] pin_last_reg;

	fdlp_sync #(.WIDTH(4)) u_sync (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RST_N),
		.i_async ({I_TX_MF_START, I_TX_REQ, I_RX_STROBE, I_RX_BIT}),
		.o_sync  (pins_sync)
	);
	assign rx_bit        = pins_sync[0];
	assign rx_strobe_lvl = pins_sync[1];
	assign tx_req_lvl    = pins_sync[2];
	assign tx_mf_lvl     = pins_sync[3];

	// rising edges of the synchronised strobes
	always @(posedge I_CLK_SYS) begin
		if (!I_RST_N)
			pin_last_reg <= 3'h0;
		else
			pin_last_reg <= {tx_mf_lvl, tx_req_lvl, rx_strobe_lvl};
	end
	wire rx_stb = rx_strobe_lvl & ~pin_last_reg[0];
	wire tx_stb = tx_req_lvl & ~pin_last_reg[1];
	wire mf_stb = tx_mf_lvl & ~pin_last_reg[2];

	// ------------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------------
	reg  [7:0] rx_byte_reg;
	reg  [7:0] match_a_reg;
	reg  [7:0] match_b_reg;
	reg  [7:0] tx_byte_reg;
	reg  [4:0] ctrl_reg;
	reg  [2:0] status_reg;
	reg  [2:0] mask_reg;
	reg  [31:0] prdata_reg;
	reg  [31:0] rdata_next;
	reg         hit_next;

	wire [9:0] idx    = I_PADDR[11:2];
	wire       access = I_PSEL & I_PENABLE;
	wire       wr     = access & I_PWRITE;
	wire       rd_set = I_PSEL & ~I_PENABLE & ~I_PWRITE;

	// read mux and address hit
	always @* begin
		rdata_next = 32'h0000_0000;
		hit_next   = 1'b1;
		if (idx == {2'h0, `FDLP_IDX_RX_BYTE})
			rdata_next = {24'h000000, rx_byte_reg};
		else if (idx == {2'h0, `FDLP_IDX_MATCH_A})
			rdata_next = {24'h000000, match_a_reg};
		else if (idx == {2'h0, `FDLP_IDX_MATCH_B})
			rdata_next = {24'h000000, match_b_reg};
		else if (idx == {2'h0, `FDLP_IDX_TX_BYTE})
			rdata_next = {24'h000000, tx_byte_reg};
		else if (idx == {2'h0, `FDLP_IDX_CTRL})
			rdata_next = {27'h0, ctrl_reg};
		else if (idx == {2'h0, `FDLP_IDX_STATUS})
			rdata_next = {29'h0, status_reg};
		else if (idx == {2'h0, `FDLP_IDX_MASK})
			rdata_next = {29'h0, mask_reg};
		else
			hit_next = 1'b0;
	end

	// read data captured in the setup cycle
	always @(posedge I_CLK_SYS) begin
		if (!I_RST_N)
			prdata_reg <= 32'h0000_0000;
		else if (rd_set)
			prdata_reg <= rdata_next;
	end

	assign O_PRDATA  = prdata_reg;
	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = access & ~hit_next;

	wire wr_ok   = wr & hit_next;
	wire wr_ma   = wr_ok & (idx == {2'h0, `FDLP_IDX_MATCH_A});
	wire wr_mb   = wr_ok & (idx == {2'h0, `FDLP_IDX_MATCH_B});
	wire wr_tx   = wr_ok & (idx == {2'h0, `FDLP_IDX_TX_BYTE});
	wire wr_ctrl = wr_ok & (idx == {2'h0, `FDLP_IDX_CTRL});
	wire wr_st   = wr_ok & (idx == {2'h0, `FDLP_IDX_STATUS});
	wire wr_mask = wr_ok & (idx == {2'h0, `FDLP_IDX_MASK});

	// plain software registers
	always @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			match_a_reg <= `FDLP_RST_BYTE;
			match_b_reg <= `FDLP_RST_BYTE;
			tx_byte_reg <= `FDLP_RST_BYTE;
			ctrl_reg    <= `FDLP_RST_CTRL;
			mask_reg    <= `FDLP_RST_FLAGS;
		end else begin
			if (wr_ma)
				match_a_reg <= I_PWDATA[7:0];
			if (wr_mb)
				match_b_reg <= I_PWDATA[7:0];
			if (wr_tx)
				tx_byte_reg <= I_PWDATA[7:0];
			if (wr_ctrl)
				ctrl_reg <= I_PWDATA[4:0];
			if (wr_mask)
				mask_reg <= I_PWDATA[2:0];
		end
	end

	wire destuff_en = ctrl_reg[`FDLP_CTRL_DESTUFF];
	wire stuff_en   = ctrl_reg[`FDLP_CTRL_STUFF];
	wire mfload_en  = ctrl_reg[`FDLP_CTRL_MFLOAD];

	// ------------------------------------------------------------------
	// receive assembly
	// ------------------------------------------------------------------
	reg  [7:0] rx_shift_reg;
	reg  [3:0] rx_cnt_reg;
	reg  [2:0] rx_ones_reg;
	reg        rx_six_reg;
	reg        rx_full_ev_reg;
	reg        rx_match_ev_reg;

	// drop the zero after exactly five ones, keep it after six or more
	wire rx_drop = destuff_en & ~rx_bit & ~rx_six_reg &
		(rx_ones_reg == `FDLP_RUN_ONES);
	wire [7:0] rx_shift_next = {rx_bit, rx_shift_reg[7:1]};

	always @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			rx_shift_reg    <= 8'h00;
			rx_cnt_reg      <= 4'h0;
			rx_ones_reg     <= 3'h0;
			rx_six_reg      <= 1'b0;
			rx_byte_reg     <= `FDLP_RST_BYTE;
			rx_full_ev_reg  <= 1'b0;
			rx_match_ev_reg <= 1'b0;
		end else begin
			rx_full_ev_reg  <= 1'b0;
			rx_match_ev_reg <= 1'b0;
			if (rx_stb) begin
				// run length of ones, saturating at six
				if (!rx_bit) begin
					rx_ones_reg <= 3'h0;
					rx_six_reg  <= 1'b0;
				end else if (rx_ones_reg == `FDLP_RUN_ONES)
					rx_six_reg <= 1'b1;
				else if (!rx_six_reg)
					rx_ones_reg <= rx_ones_reg + 3'h1;
				if (!rx_drop) begin
					rx_shift_reg <= rx_shift_next;
					if (rx_cnt_reg == 4'h7) begin
						rx_cnt_reg     <= 4'h0;
						rx_byte_reg    <= rx_shift_next;
						rx_full_ev_reg <= 1'b1;
						rx_match_ev_reg <=
							(rx_shift_next == match_a_reg) |
							(rx_shift_next == match_b_reg);
					end else
						rx_cnt_reg <= rx_cnt_reg + 4'h1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// transmit serialiser
	// ------------------------------------------------------------------
	reg  [7:0] tx_shift_reg;
	reg  [3:0] tx_cnt_reg;
	reg  [2:0] tx_ones_reg;
	reg        tx_pend_reg;
	reg        tx_bit_reg;
	reg        tx_valid_reg;
	reg        tx_empty_ev_reg;

	// a written byte waits for the next multiframe when deferral is on
	wire tx_reload = (tx_cnt_reg == 4'h8) & (~mfload_en | tx_pend_reg);
	wire tx_stuff  = stuff_en & (tx_ones_reg == `FDLP_RUN_ONES);

	always @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			tx_shift_reg    <= 8'h00;
			tx_cnt_reg      <= 4'h8;
			tx_ones_reg     <= 3'h0;
			tx_pend_reg     <= 1'b0;
			tx_bit_reg      <= 1'b0;
			tx_valid_reg    <= 1'b0;
			tx_empty_ev_reg <= 1'b0;
		end else begin
			tx_valid_reg    <= 1'b0;
			tx_empty_ev_reg <= 1'b0;
			if (mf_stb & (tx_cnt_reg == 4'h8))  // boundary after byte done
				tx_pend_reg <= 1'b1;
			if (tx_reload) begin
				// reload repeats the held byte if none was written
				tx_shift_reg <= tx_byte_reg;
				tx_cnt_reg   <= 4'h0;
				tx_pend_reg  <= 1'b0;
			end else if (tx_stb & (tx_cnt_reg != 4'h8)) begin
				tx_valid_reg <= 1'b1;
				if (tx_stuff) begin
					tx_bit_reg  <= 1'b0;
					tx_ones_reg <= 3'h0;
				end else begin
					tx_bit_reg   <= tx_shift_reg[0];
					tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
					tx_cnt_reg   <= tx_cnt_reg + 4'h1;
					tx_ones_reg  <= tx_shift_reg[0] ?
						tx_ones_reg + 3'h1 : 3'h0;
					if (tx_cnt_reg == 4'h7)
						tx_empty_ev_reg <= 1'b1;
				end
			end
		end
	end

	assign O_TX_BIT   = tx_bit_reg;
	assign O_TX_VALID = tx_valid_reg;

	// ------------------------------------------------------------------
	// sticky status and interrupt
	// ------------------------------------------------------------------
	wire [2:0] ev;
	assign ev[`FDLP_ST_MATCH]   = rx_match_ev_reg;
	assign ev[`FDLP_ST_TXEMPTY] = tx_empty_ev_reg;
	assign ev[`FDLP_ST_RXFULL]  = rx_full_ev_reg;
	wire [2:0] clr = wr_st ? I_PWDATA[2:0] : 3'h0;

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_flag
			// a set in the clear cycle wins
			always @(posedge I_CLK_SYS) begin
				if (!I_RST_N)
					status_reg[g] <= 1'b0;
				else if (ev[g])
					status_reg[g] <= 1'b1;
				else if (clr[g])
					status_reg[g] <= 1'b0;
			end
		end
	endgenerate

	reg int_n_reg;
	always @(posedge I_CLK_SYS) begin
		if (!I_RST_N)
			int_n_reg <= 1'b1;
		else
			int_n_reg <= ~|(status_reg & mask_reg);
	end
	assign O_INT_N = int_n_reg;
endmodule

// ---- verif/fdlp_properties.sv ----
// port assertions of the link byte port
`timescale 1ns/100ps
module fdlp_properties (
	input wire        I_CLK_SYS,
	input wire        I_RST_N,
	input wire        I_PSEL,
	input wire        I_PENABLE,
	input wire        I_PWRITE,
	input wire [11:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	input wire        I_TX_REQ,
	input wire [31:0] O_PRDATA,
	input wire        O_PREADY,
	input wire        O_PSLVERR,
	input wire        O_TX_BIT,
	input wire        O_TX_VALID,
	input wire        O_INT_N
);
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RST_N);
	// word index of the access and its decode
	wire [9:0] idx = I_PADDR[11:2];
	wire       hit = idx == 10'h28 || idx == 10'h29 || idx == 10'h2a
		|| idx == 10'h7e || idx == 10'h80 || idx == 10'h81 || idx == 10'h82;
	sequence s_acc;
		I_PSEL && I_PENABLE;
	endsequence
	sequence s_mask_off;
		s_acc ##0 I_PWRITE && idx == 10'h82 && I_PWDATA[2:0] == 3'h0;
	endsequence
	chk_ready_high: assert property (O_PREADY)
		else $error("ready dropped");
	chk_unmapped_err: assert property (s_acc ##0 !hit |-> O_PSLVERR)
		else $error("unmapped access not refused");
	chk_mapped_ok: assert property (s_acc ##0 hit |-> !O_PSLVERR)
		else $error("mapped access refused");
	chk_upper_zero: assert property (O_PRDATA[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_read_hold: assert property (!$stable(O_PRDATA)
		|-> $past(I_PSEL && !I_PENABLE && !I_PWRITE))
		else $error("read data moved outside setup");
	chk_mask_quiet: assert property (s_mask_off |-> ##[1:2] O_INT_N)
		else $error("interrupt with all masked");
	chk_valid_pulse: assert property (O_TX_VALID |=> !O_TX_VALID[*2])
		else $error("valid longer than a pulse");
	chk_valid_cause: assert property ((!I_TX_REQ)[*6] |-> !O_TX_VALID)
		else $error("bit sent without a slot request");
	chk_bit_hold: assert property (!O_TX_VALID |-> $stable(O_TX_BIT))
		else $error("tx bit moved between slots");
endmodule
bind fdlp_top fdlp_properties u_props (
	.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
	.I_PWDATA(I_PWDATA), .I_TX_REQ(I_TX_REQ), .O_PRDATA(O_PRDATA),
	.O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_TX_BIT(O_TX_BIT),
	.O_TX_VALID(O_TX_VALID), .O_INT_N(O_INT_N)
);

// ---- verif/fdlp_link_model.sv ----
// far-side framer model: rx bit strobes, tx slot requests, boundaries
`timescale 1ns/100ps
module fdlp_link_model (
	input  wire  clk,
	input  wire  tx_bit,
	input  wire  tx_valid,
	output logic rx_bit,
	output logic rx_strobe,
	output logic tx_req,
	output logic mf_start
);
	// lines idle at time zero
	initial begin
		rx_bit = 1'b0;
		rx_strobe = 1'b0;
		tx_req = 1'b0;
		mf_start = 1'b0;
	end
	// one received bit, steady around the strobe, inverted afterwards
	task rx(input logic b);
		rx_bit <= b;
		repeat (4) @(posedge clk);
		rx_strobe <= 1'b1;
		repeat (6) @(posedge clk);
		rx_strobe <= 1'b0;
		rx_bit <= ~b;
		repeat (4) @(posedge clk);
	endtask
	// one slot request, waits a bounded time for the bit
	task tx(output logic b, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		tx_req <= 1'b1;
		while (!ok && n < 10) begin
			@(posedge clk);
			n++;
			ok = (tx_valid === 1'b1);
		end
		b = tx_bit;
		tx_req <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// multiframe boundary pulse
	task mf;
		mf_start <= 1'b1;
		repeat (4) @(posedge clk);
		mf_start <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ---- verif/test_t1_facility_data_link_byte_port.sv ----
// self-checking bench of the link byte port
`timescale 1ns/100ps
`include "fdlp_regs.vh"
module test_t1_facility_data_link_byte_port;
	// ----
	// signals and instances
	// ----
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	wire  [31:0] prd;
	wire         rdy, err, rxb, rxs, treq, mfs, txb, txv, int_n;
	int          bad_count = 0;
	int          compares = 0;
	logic [31:0] q;
	logic        e, b, ok;
	logic [15:0] got;
	// 200 MHz clock
	always #2.5 clk = ~clk;
	fdlp_top DUT (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err), .I_RX_BIT(rxb),
		.I_RX_STROBE(rxs), .I_TX_REQ(treq), .I_TX_MF_START(mfs),
		.O_TX_BIT(txb), .O_TX_VALID(txv), .O_INT_N(int_n));
	fdlp_link_model link (.clk(clk), .tx_bit(txb), .tx_valid(txv),
		.rx_bit(rxb), .rx_strobe(rxs), .tx_req(treq), .mf_start(mfs));
	// ----
	// shared tasks
	// ----
	task close_out;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task chk(input string s, input logic [31:0] x, input logic [31:0] y);
		compares++;
		if (y !== x) begin
			bad_count++;
			$display("BAD %s exp %h got %h", s, x, y);
		end
	endtask
	// apb transfer: setup, then access until ready
	task apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (rdy !== 1'b1) begin
			bad_count++;
			close_out;
		end
		q = prd;
		e = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task rd(input logic [7:0] i, input logic [31:0] x, input string s);
		apb(1'b0, i, 32'h0);
		chk(s, x, q);
	endtask
	task rxbits(input logic [15:0] v, input int n);
		for (int k = 0; k < n; k++) link.rx(v[k]);
	endtask
	task txbits(input int n);
		got = 16'h0;
		for (int k = 0; k < n; k++) begin
			link.tx(b, ok);
			chk("tx valid", 1, ok);
			got[k] = b;
		end
	endtask
	// ----
	// scenarios
	// ----
	task t_regs;
		apb(1'b0, 8'h00, 32'h0);
		chk("unmapped err", 1, e);
		chk("unmapped data", 0, q);
		rd(`FDLP_IDX_TX_BYTE, 32'h0, "tx byte");
		apb(1'b1, `FDLP_IDX_MATCH_A, 32'h1a5);
		rd(`FDLP_IDX_MATCH_A, 32'ha5, "match a");
		apb(1'b1, `FDLP_IDX_MATCH_B, 32'h3f);
		apb(1'b1, `FDLP_IDX_MASK, 32'h7);
	endtask
	task t_rx;
		rxbits(16'ha5, 8);
		rd(`FDLP_IDX_RX_BYTE, 32'ha5, "rx byte");
		rd(`FDLP_IDX_STATUS, 32'h5, "status");
		chk("int on", 0, int_n);
		apb(1'b1, `FDLP_IDX_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk("int masked", 1, int_n);
		apb(1'b1, `FDLP_IDX_MASK, 32'h7);
		apb(1'b1, `FDLP_IDX_STATUS, 32'h7);
		repeat (2) @(posedge clk);
		chk("int cleared", 1, int_n);
	endtask
	task t_destuff;
		apb(1'b1, `FDLP_IDX_CTRL, 32'h1);
		rxbits(16'h0be, 9);
		rd(`FDLP_IDX_RX_BYTE, 32'h7e, "destuffed");
		rxbits(16'h3f, 8);
		rd(`FDLP_IDX_RX_BYTE, 32'h3f, "six ones");
		rd(`FDLP_IDX_STATUS, 32'h5, "match b");
	endtask
	task t_tx;
		apb(1'b1, `FDLP_IDX_CTRL, 32'h11);
		apb(1'b1, `FDLP_IDX_STATUS, 32'h7);
		apb(1'b1, `FDLP_IDX_TX_BYTE, 32'h1c);
		txbits(8);
		chk("first byte", 32'h0, got);
		rd(`FDLP_IDX_STATUS, 32'h2, "tx empty");
		chk("int empty", 0, int_n);
		txbits(8);
		chk("lsb first", 32'h1c, got);
		txbits(8);
		chk("repeat", 32'h1c, got);
	endtask
	task t_stuff;
		apb(1'b1, `FDLP_IDX_CTRL, 32'h3);
		apb(1'b1, `FDLP_IDX_TX_BYTE, 32'hff);
		txbits(8);
		chk("drain", 32'h1c, got);
		txbits(9);
		chk("stuffed", 32'h1df, got);
	endtask
	task t_mf;
		apb(1'b1, `FDLP_IDX_CTRL, 32'h4);
		apb(1'b1, `FDLP_IDX_TX_BYTE, 32'h1c);
		txbits(8);
		chk("unstuffed", 32'hff, got);
		link.tx(b, ok);
		chk("held", 0, ok);
		link.mf;
		txbits(8);
		chk("mf load", 32'h1c, got);
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_rx;
		t_destuff;
		t_tx;
		t_stuff;
		t_mf;
		close_out;
	end
endmodule
